// *** hdl/char_lcd_pkg.sv ***
// Shared constants for the character display instruction decoder.
// Assumes a single 10 MHz system clock; times are kept in ns here and converted to cycles in the decoder.
package char_lcd_pkg;
    // Instruction execution times at the reference oscillator, in ns.
    localparam int unsigned EXEC_SHORT_NS = 37000;
    localparam int unsigned EXEC_LONG_NS  = 1520000;
    localparam int unsigned ADDR_UPD_NS   = 4000;
    localparam int unsigned REF_OSC_KHZ   = 270;
    localparam int unsigned CLK_PERIOD_NS = 100;
    // Reset values and fixed codes.
    localparam logic [7:0]  BLANK_CODE    = 8'h20;
    localparam logic        RST_BUS_WIDTH = 1'b1;
    localparam logic        RST_INCR      = 1'b1;
    localparam int unsigned TEXT_DEPTH    = 128;
    localparam int unsigned GLYPH_DEPTH   = 64;
    // Controller states, one-hot.
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_EXEC  = 4'b0010,
        S_CLEAR = 4'b0100,
        S_AUPD  = 4'b1000
    } ctl_state_t;
    // Instruction classes by leading one.
    typedef enum logic [3:0] {
        C_NONE, C_CLEAR, C_HOME, C_ENTRY, C_DISP, C_SHIFT, C_FUNC, C_GLYPH, C_TEXT
    } cmd_class_t;
endpackage

// *** hdl/host_bus_port.sv ***
// Host bus front end: synchronises the host pins and assembles bytes.
// Assumes the strobe and bus lines are asynchronous to mclk_i.
`timescale 1ns/100ps
module host_bus_port (
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    input  wire logic       strobe_i,
    input  wire logic       register_select_line_i,
    input  wire logic       rw_i,
    input  wire logic [7:0] data_i,
    input  wire logic       bus_width_select_i,
    output logic            xfer_o,
    output logic            xfer_rs_o,
    output logic            xfer_rw_o,
    output logic [7:0]      xfer_byte_o,
    output logic            low_phase_o,
    output logic            rs_o,
    output logic            rw_o,
    output logic            strobe_o
);
    // ****************************************
    // Synchronisers
    // ****************************************
    logic [10:0] meta_ff;
    logic [10:0] sync_ff;
    logic        strobe_d_ff;
    logic        phase_ff;
    logic [3:0]  hi_nib_ff;
    logic        nxt_phase;
    logic [3:0]  nxt_hi_nib;
    logic        fall;

    // Two flops before any logic looks at the pins.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_ff     <= 11'h000;
            sync_ff     <= 11'h000;
            strobe_d_ff <= 1'b0;
            phase_ff    <= 1'b0;
            hi_nib_ff   <= 4'h0;
        end else begin
            meta_ff     <= {strobe_i, register_select_line_i, rw_i, data_i};
            sync_ff     <= meta_ff;
            strobe_d_ff <= sync_ff[10];
            phase_ff    <= nxt_phase;
            hi_nib_ff   <= nxt_hi_nib;
        end
    end

    // ****************************************
    // Byte assembly
    // ****************************************
    // Data is latched on the falling strobe, as the host holds it stable then.
    // nibble pairing
    always_comb begin
        fall        = strobe_d_ff & ~sync_ff[10];
        nxt_phase   = phase_ff;
        nxt_hi_nib  = hi_nib_ff;
        xfer_o      = 1'b0;
        xfer_byte_o = sync_ff[7:0];
        if (bus_width_select_i) begin
            nxt_phase = 1'b0;
            xfer_o    = fall;
        end else if (fall) begin
            nxt_phase = ~phase_ff;
            if (!phase_ff) begin
                nxt_hi_nib = sync_ff[7:4];
            end else begin
                xfer_o = 1'b1;
            end
            xfer_byte_o = {hi_nib_ff, sync_ff[7:4]};
        end
    end

    assign xfer_rs_o   = sync_ff[9];
    assign xfer_rw_o   = sync_ff[8];
    assign rs_o        = sync_ff[9];
    assign rw_o        = sync_ff[8];
    assign strobe_o    = sync_ff[10];
    assign low_phase_o = phase_ff;
endmodule

// *** hdl/char_lcd_instruction_decoder.sv ***
// Instruction decoder and executor of a character display controller.
// Assumes host pins asynchronous to mclk_i; display drive lives elsewhere.
// How it works
// - Clear fills text RAM blank, pointer zero.
// - Home zeroes pointer and shift, long time.
// - Entry mode stores direction and shift option.
// - Display control stores display, cursor, blink.
// - Shift command moves cursor or display only.
// - Function set stores width, lines, font.
// - Glyph address command loads pointer, glyph target.
// - Text address command loads pointer, text target.
// - Status read returns busy and pointer.
// - Data transfers step pointer by entry direction.
// - Pointer steps after busy ends plus delay.
// - Execution times scale with oscillator frequency.
// - Data write stores into last-addressed RAM.
// - Narrow bus carries bytes high nibble first.
// - Cursor shift decrements left, increments right.
`timescale 1ns/100ps
module char_lcd_instruction_decoder #(
    parameter int unsigned OSC_KHZ  = char_lcd_pkg::REF_OSC_KHZ,
    parameter int unsigned LONG_CYC = char_lcd_pkg::EXEC_LONG_NS / char_lcd_pkg::CLK_PERIOD_NS
                                      * char_lcd_pkg::REF_OSC_KHZ / OSC_KHZ
) (
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    input  wire logic       strobe_i,
    input  wire logic       register_select_line_i,
    input  wire logic       rw_i,
    input  wire logic [7:0] data_i,
    output logic [7:0]      data_o,
    output logic            data_oe_o,
    output logic            busy_indicator_o,
    output logic [6:0]      address_pointer_o,
    output logic            display_on_o,
    output logic            cursor_on_o,
    output logic            blink_on_o,
    output logic            two_line_o,
    output logic            font_large_o,
    output logic            bus_width_select_o,
    output logic [6:0]      display_offset_o
);
    // ****************************************
    // Timing
    // ****************************************
    // All times round down; never below one cycle.
    localparam int unsigned SHORT_CYC = char_lcd_pkg::EXEC_SHORT_NS / char_lcd_pkg::CLK_PERIOD_NS
                                        * char_lcd_pkg::REF_OSC_KHZ / OSC_KHZ;
    localparam int unsigned AUPD_CYC  = char_lcd_pkg::ADDR_UPD_NS / char_lcd_pkg::CLK_PERIOD_NS
                                        * char_lcd_pkg::REF_OSC_KHZ / OSC_KHZ;

    function automatic char_lcd_pkg::cmd_class_t classify(input logic [7:0] b);
        if (b[7])      return char_lcd_pkg::C_TEXT;
        else if (b[6]) return char_lcd_pkg::C_GLYPH;
        else if (b[5]) return char_lcd_pkg::C_FUNC;
        else if (b[4]) return char_lcd_pkg::C_SHIFT;
        else if (b[3]) return char_lcd_pkg::C_DISP;
        else if (b[2]) return char_lcd_pkg::C_ENTRY;
        else if (b[1]) return char_lcd_pkg::C_HOME;
        else if (b[0]) return char_lcd_pkg::C_CLEAR;
        else           return char_lcd_pkg::C_NONE;
    endfunction

    // Pointer arithmetic; glyph addresses wrap within six bits.
    function automatic logic [6:0] step(input logic [6:0] p, input logic up, input logic g);
        logic [6:0] r;
        r = up ? 7'(p + 7'h01) : 7'(p - 7'h01);
        return g ? {1'b0, r[5:0]} : r;
    endfunction

    // ****************************************
    // Host front end
    // ****************************************
    logic       xfer;
    logic       xfer_rs;
    logic       xfer_rw;
    logic [7:0] xbyte;
    logic       low_phase;
    logic       rs_s;
    logic       rw_s;
    logic       strobe_s;

    host_bus_port u_port (
        .mclk_i                 (mclk_i),
        .reset_n_i              (reset_n_i),
        .strobe_i               (strobe_i),
        .register_select_line_i (register_select_line_i),
        .rw_i                   (rw_i),
        .data_i                 (data_i),
        .bus_width_select_i     (bus_width_select_o),
        .xfer_o                 (xfer),
        .xfer_rs_o              (xfer_rs),
        .xfer_rw_o              (xfer_rw),
        .xfer_byte_o            (xbyte),
        .low_phase_o            (low_phase),
        .rs_o                   (rs_s),
        .rw_o                   (rw_s),
        .strobe_o               (strobe_s)
    );

    // ****************************************
    // Control state
    // ****************************************
    char_lcd_pkg::ctl_state_t state_ff, nxt_state;
    logic [19:0] cnt_ff, nxt_cnt;
    logic [6:0]  ptr_ff, nxt_ptr, cur_ptr, ofs_ff, nxt_ofs;
    logic        glyph_ff, nxt_glyph, incr_ff, nxt_incr, eshift_ff, nxt_eshift;
    logic [2:0]  disp_ff, nxt_disp;
    logic [2:0]  func_ff, nxt_func;
    logic        accept, wr_ram;
    logic        xfer_rs_pend_ff, nxt_pend;
    logic [7:0]  rdbyte, nxt_dout;
    logic        nxt_oe;
    logic [7:0]  text_ram [char_lcd_pkg::TEXT_DEPTH];
    logic [7:0]  glyph_ram [char_lcd_pkg::GLYPH_DEPTH];
    char_lcd_pkg::cmd_class_t cls;

    assign accept = xfer && !(xfer_rs == 1'b0 && xfer_rw == 1'b1)
                    && (state_ff == char_lcd_pkg::S_IDLE || state_ff == char_lcd_pkg::S_AUPD);
    assign cls    = classify(xbyte);
    assign wr_ram = accept && xfer_rs && !xfer_rw;

    // Next-state logic for the whole controller.
    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_ptr    = ptr_ff;
        nxt_ofs    = ofs_ff;
        nxt_glyph  = glyph_ff;
        nxt_incr   = incr_ff;
        nxt_eshift = eshift_ff;
        nxt_disp   = disp_ff;
        nxt_func   = func_ff;
        cur_ptr    = (state_ff == char_lcd_pkg::S_AUPD) ? step(ptr_ff, incr_ff, glyph_ff) : ptr_ff;
        case (state_ff)
            char_lcd_pkg::S_IDLE: ;
            char_lcd_pkg::S_EXEC: begin
                nxt_cnt = 20'(cnt_ff - 20'h1);
                if (cnt_ff <= 20'h1) begin
                    nxt_state = char_lcd_pkg::S_IDLE;
                    if (xfer_rs_pend_ff) begin
                        nxt_state = char_lcd_pkg::S_AUPD;
                        nxt_cnt   = 20'(AUPD_CYC);
                    end
                end
            end
            char_lcd_pkg::S_CLEAR: begin
                nxt_cnt = 20'(cnt_ff + 20'h1);
                if (cnt_ff == 20'(char_lcd_pkg::TEXT_DEPTH - 1)) begin
                    nxt_state = char_lcd_pkg::S_EXEC;
                    nxt_cnt   = 20'(LONG_CYC);
                    nxt_ptr   = 7'h00;
                    nxt_ofs   = 7'h00;
                    nxt_glyph = 1'b0;
                    nxt_incr  = 1'b1;
                end
            end
            char_lcd_pkg::S_AUPD: begin
                nxt_cnt = 20'(cnt_ff - 20'h1);
                if (cnt_ff <= 20'h1) begin
                    nxt_state = char_lcd_pkg::S_IDLE;
                    nxt_ptr   = cur_ptr;
                end
            end
            default: nxt_state = char_lcd_pkg::S_IDLE;
        endcase
        if (accept) begin
            nxt_ptr   = cur_ptr;
            nxt_state = char_lcd_pkg::S_EXEC;
            nxt_cnt   = 20'(SHORT_CYC);
            if (xfer_rs) begin
                // data write, display shift on entry
                if (!xfer_rw && !glyph_ff && eshift_ff) begin
                    nxt_ofs = incr_ff ? 7'(ofs_ff + 7'h01) : 7'(ofs_ff - 7'h01);
                end
            end else begin
                case (cls)
                    char_lcd_pkg::C_CLEAR: begin
                        nxt_state = char_lcd_pkg::S_CLEAR;
                        nxt_cnt   = 20'h0;
                    end
                    char_lcd_pkg::C_HOME: begin
                        nxt_ptr   = 7'h00;
                        nxt_ofs   = 7'h00;
                        nxt_glyph = 1'b0;
                        nxt_cnt   = 20'(LONG_CYC);
                    end
                    char_lcd_pkg::C_ENTRY: begin
                        nxt_incr   = xbyte[1];
                        nxt_eshift = xbyte[0];
                    end
                    char_lcd_pkg::C_DISP: nxt_disp = xbyte[2:0];
                    char_lcd_pkg::C_SHIFT: begin
                        if (xbyte[3]) begin
                            nxt_ofs = xbyte[2] ? 7'(ofs_ff - 7'h01) : 7'(ofs_ff + 7'h01);
                        end else begin
                            nxt_ptr = step(cur_ptr, xbyte[2], glyph_ff);
                        end
                    end
                    char_lcd_pkg::C_FUNC: nxt_func = xbyte[4:2];
                    char_lcd_pkg::C_GLYPH: begin
                        nxt_ptr   = {1'b0, xbyte[5:0]};
                        nxt_glyph = 1'b1;
                    end
                    char_lcd_pkg::C_TEXT: begin
                        nxt_ptr   = xbyte[6:0];
                        nxt_glyph = 1'b0;
                    end
                    default: nxt_state = char_lcd_pkg::S_IDLE;
                endcase
            end
        end
    end

    // Data transfers leave a step pending until busy drops.
    // step after transfer
    assign nxt_pend = accept ? xfer_rs : xfer_rs_pend_ff;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff        <= char_lcd_pkg::S_IDLE;
            cnt_ff          <= 20'h0;
            ptr_ff          <= 7'h00;
            ofs_ff          <= 7'h00;
            glyph_ff        <= 1'b0;
            incr_ff         <= char_lcd_pkg::RST_INCR;
            eshift_ff       <= 1'b0;
            disp_ff         <= 3'h0;
            func_ff         <= {char_lcd_pkg::RST_BUS_WIDTH, 2'h0};
            xfer_rs_pend_ff <= 1'b0;
            data_o          <= 8'h00;
            data_oe_o       <= 1'b0;
        end else begin
            state_ff        <= nxt_state;
            cnt_ff          <= nxt_cnt;
            ptr_ff          <= nxt_ptr;
            ofs_ff          <= nxt_ofs;
            glyph_ff        <= nxt_glyph;
            incr_ff         <= nxt_incr;
            eshift_ff       <= nxt_eshift;
            disp_ff         <= nxt_disp;
            func_ff         <= nxt_func;
            xfer_rs_pend_ff <= nxt_pend;
            data_o          <= nxt_dout;
            data_oe_o       <= nxt_oe;
        end
    end

    // RAM writes; contents are not reset, clear is done by instruction.
    always_ff @(posedge mclk_i) begin
        if (state_ff == char_lcd_pkg::S_CLEAR) begin
            text_ram[cnt_ff[6:0]] <= char_lcd_pkg::BLANK_CODE;
        end else if (wr_ram && glyph_ff) begin
            glyph_ram[cur_ptr[5:0]] <= xbyte;
        end else if (wr_ram) begin
            text_ram[cur_ptr] <= xbyte;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // status word
    always_comb begin
        // A data read inside the update wait must see the stepped address.
        rdbyte = glyph_ff ? glyph_ram[cur_ptr[5:0]] : text_ram[cur_ptr];
        if (!rs_s) begin
            rdbyte = {busy_indicator_o, ptr_ff};
        end
        nxt_dout = rdbyte;
        if (!bus_width_select_o) begin
            nxt_dout = low_phase ? {rdbyte[3:0], 4'h0} : {rdbyte[7:4], 4'h0};
        end
        nxt_oe = strobe_s & rw_s;
    end

    assign busy_indicator_o   = state_ff == char_lcd_pkg::S_EXEC || state_ff == char_lcd_pkg::S_CLEAR;
    assign address_pointer_o  = ptr_ff;
    assign display_on_o       = disp_ff[2];
    assign cursor_on_o        = disp_ff[1];
    assign blink_on_o         = disp_ff[0];
    assign bus_width_select_o = func_ff[2];
    assign two_line_o         = func_ff[1];
    assign font_large_o       = func_ff[0];
    assign display_offset_o   = ofs_ff;

    // ****************************************
    // Assertions
    // ****************************************
    logic cmd_ok;
    assign cmd_ok = accept && !xfer_rs;

    property p_clear_start;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cmd_ok && cls == char_lcd_pkg::C_CLEAR |=> state_ff == char_lcd_pkg::S_CLEAR && busy_indicator_o;
    endproperty
    a_clear_start: assert property (p_clear_start) else $error("clear did not start");
    property p_clear_end;
        @(posedge mclk_i) disable iff (!reset_n_i)
        state_ff == char_lcd_pkg::S_CLEAR && nxt_state == char_lcd_pkg::S_EXEC
        |=> ptr_ff == 7'h00 && incr_ff && !glyph_ff;
    endproperty
    a_clear_end: assert property (p_clear_end) else $error("clear left pointer set");
    property p_home;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cmd_ok && cls == char_lcd_pkg::C_HOME |=> ptr_ff == 7'h00 && ofs_ff == 7'h00
        && cnt_ff == 20'(LONG_CYC);
    endproperty
    a_home: assert property (p_home) else $error("home failed");
    property p_entry;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cmd_ok && cls == char_lcd_pkg::C_ENTRY |=> incr_ff == $past(xbyte[1])
        && eshift_ff == $past(xbyte[0]);
    endproperty
    a_entry: assert property (p_entry) else $error("entry mode not stored");
    property p_disp;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cmd_ok && cls == char_lcd_pkg::C_DISP |=> display_on_o == $past(xbyte[2])
        && blink_on_o == $past(xbyte[0]);
    endproperty
    a_disp: assert property (p_disp) else $error("display flags wrong");
    property p_glyph;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cmd_ok && cls == char_lcd_pkg::C_GLYPH |=> glyph_ff && ptr_ff == {1'b0, $past(xbyte[5:0])};
    endproperty
    a_glyph: assert property (p_glyph) else $error("glyph address wrong");
    property p_text;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cmd_ok && cls == char_lcd_pkg::C_TEXT |=> !glyph_ff && ptr_ff == $past(xbyte[6:0]);
    endproperty
    a_text: assert property (p_text) else $error("text address wrong");
    property p_busy_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
        accept && xfer_rs |=> busy_indicator_o [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_step;
        @(posedge mclk_i) disable iff (!reset_n_i)
        state_ff == char_lcd_pkg::S_AUPD && cnt_ff == 20'h1 && !accept
        |=> ptr_ff == step($past(ptr_ff), incr_ff, glyph_ff) && !busy_indicator_o;
    endproperty
    a_step: assert property (p_step) else $error("pointer step wrong");
endmodule

// *** tb/host_model.sv ***
// Host processor model for the display controller bus.
// Assumes mclk_i at 10 MHz; pins change on its falling edge.
`timescale 1ns/100ps
module host_model (
    input  wire logic       mclk_i,
    input  wire logic [7:0] data_i,
    output logic            strobe_o,
    output logic            rs_o,
    output logic            rw_o,
    output logic [7:0]      data_o
);
    logic narrow = 1'b0;

    // Pins idle low; the bus starts at a defined value.
    initial begin
        strobe_o = 1'b0;
        rs_o = 1'b0;
        rw_o = 1'b0;
        data_o = 8'h00;
    end

    // One strobe. The bus is scrambled after the hold so stale data never passes.
    task automatic pulse(input logic rs, input logic rw, input logic [7:0] d,
                         output logic [7:0] q);
        @(negedge mclk_i);
        rs_o = rs;
        rw_o = rw;
        data_o = d;
        @(negedge mclk_i);
        strobe_o = 1'b1;
        repeat (6) @(negedge mclk_i);
        @(posedge mclk_i);
        q = data_i;
        @(negedge mclk_i);
        strobe_o = 1'b0;
        repeat (4) @(negedge mclk_i);
        data_o = ~d;
    endtask

    task automatic op(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
        logic [7:0] a;
        logic [7:0] b;
        if (narrow) begin
            pulse(rs, rw, {d[7:4], ~d[3:0]}, a);
            pulse(rs, rw, {d[3:0], ~d[7:4]}, b);
            q = {a[7:4], b[7:4]};
        end else begin
            pulse(rs, rw, d, q);
        end
    endtask

    task automatic poll(output logic [7:0] q);
        op(1'b0, 1'b1, 8'h00, q);
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the display instruction decoder.
// Assumes the host model on the far side and a shortened long time.
`timescale 1ns/100ps
module testbench;
    localparam int LONG = 50;
    logic       mclk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       strobe, rs, rw, oe, busy, d_on, c_on, b_on, two, font, wide;
    logic [7:0] hd, dq, rd, q, r;
    logic [6:0] ptr, ofs;
    int         n_mismatch = 0;
    int         cmp_count = 0;
    int         bcnt = 0;
    int         blen = 0;

    // Clock, and the shared data line seen by the host.
    always #50 mclk_i = ~mclk_i;
    assign rd = oe ? dq : ~hd;

    host_model u_host (.mclk_i(mclk_i), .data_i(rd), .strobe_o(strobe), .rs_o(rs),
                       .rw_o(rw), .data_o(hd));
    char_lcd_instruction_decoder #(.LONG_CYC(LONG)) u_dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .strobe_i(strobe),
        .register_select_line_i(rs), .rw_i(rw), .data_i(hd), .data_o(dq),
        .data_oe_o(oe), .busy_indicator_o(busy), .address_pointer_o(ptr),
        .display_on_o(d_on), .cursor_on_o(c_on), .blink_on_o(b_on), .two_line_o(two),
        .font_large_o(font), .bus_width_select_o(wide), .display_offset_o(ofs));

    // Length of the last busy period, to judge execution times.
    always @(posedge mclk_i) begin
        if (busy === 1'b1) bcnt <= bcnt + 1;
        else if (bcnt != 0) begin
            blen <= bcnt;
            bcnt <= 0;
        end
    end

    // ****************************************
    // Compare and bus helpers
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_len(input int lo, input int hi);
        cmp_count++;
        if (blen < lo || blen > hi) begin
            n_mismatch++;
            $display("[ERR] %0t busy lasted %0d cycles", $time, blen);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Polls until idle; a stuck busy ends the run.
    task automatic idle();
        int n;
        for (n = 0; n < 300; n++) begin
            u_host.poll(q);
            if (q[7] === 1'b0) break;
        end
        if (n == 300) begin
            n_mismatch++;
            $display("[ERR] %0t busy never cleared", $time);
            conclude();
        end
    endtask
    task automatic cmd(input logic s, input logic w, input logic [7:0] b);
        u_host.op(s, w, b, r);
        idle();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_setup();
        chk({wide, two, font, d_on, c_on, b_on, busy, 1'b0}, 8'h80);
        cmd(1'b0, 1'b0, 8'h3f);
        chk({5'h00, wide, two, font}, 8'h07);
        chk_len(368, 372);
        for (int i = 8; i < 16; i++) begin
            cmd(1'b0, 1'b0, 8'(i));
            chk({5'h00, d_on, c_on, b_on}, 8'(i & 7));
        end
    endtask
    task automatic t_data();
        cmd(1'b0, 1'b0, 8'h85);
        cmd(1'b1, 1'b0, 8'h41);
        chk({1'b0, ptr}, 8'h05);
        repeat (45) @(negedge mclk_i);
        chk({1'b0, ptr}, 8'h06);
        cmd(1'b0, 1'b0, 8'h04);
        cmd(1'b1, 1'b0, 8'h42);
        repeat (45) @(negedge mclk_i);
        chk({1'b0, ptr}, 8'h05);
        cmd(1'b0, 1'b0, 8'h85);
        cmd(1'b1, 1'b1, 8'h00);
        chk(r, 8'h41);
        cmd(1'b0, 1'b0, 8'h86);
        cmd(1'b1, 1'b1, 8'h00);
        chk(r, 8'h42);
    endtask
    task automatic t_shift();
        cmd(1'b0, 1'b0, 8'h90);
        cmd(1'b0, 1'b0, 8'h10);
        chk({1'b0, ptr}, 8'h0f);
        cmd(1'b0, 1'b0, 8'h17);
        chk({1'b0, ptr}, 8'h10);
        cmd(1'b0, 1'b0, 8'h18);
        chk({1'b0, ofs}, 8'h01);
        chk({1'b0, ptr}, 8'h10);
        cmd(1'b0, 1'b0, 8'h03);
        chk({1'b0, ofs}, 8'h00);
        chk({1'b0, ptr}, 8'h00);
        chk_len(LONG - 2, LONG + 2);
        cmd(1'b0, 1'b0, 8'h07);
        cmd(1'b1, 1'b0, 8'h33);
        chk({1'b0, ofs}, 8'h01);
        cmd(1'b0, 1'b0, 8'h06);
    endtask
    task automatic t_busy();
        cmd(1'b0, 1'b0, 8'h92);
        chk(q, 8'h12);
        u_host.op(1'b0, 1'b0, 8'h0c, r);
        u_host.poll(q);
        chk(q, 8'h92);
        u_host.op(1'b0, 1'b0, 8'h08, r);
        idle();
        chk({7'h00, d_on}, 8'h01);
    endtask
    task automatic t_clear();
        cmd(1'b0, 1'b0, 8'h01);
        chk_len(128 + LONG - 2, 128 + LONG + 2);
        chk({1'b0, ptr}, 8'h00);
        cmd(1'b1, 1'b0, 8'h55);
        repeat (45) @(negedge mclk_i);
        chk({1'b0, ptr}, 8'h01);
        cmd(1'b0, 1'b0, 8'h85);
        cmd(1'b1, 1'b1, 8'h00);
        chk(r, 8'h20);
        cmd(1'b0, 1'b0, 8'h7f);
        chk({1'b0, ptr}, 8'h3f);
        cmd(1'b1, 1'b0, 8'h15);
        cmd(1'b0, 1'b0, 8'h7f);
        cmd(1'b1, 1'b1, 8'h00);
        chk(r, 8'h15);
    endtask
    task automatic t_nibble();
        u_host.op(1'b0, 1'b0, 8'h2c, r);
        repeat (400) @(negedge mclk_i);
        u_host.narrow = 1'b1;
        chk({7'h00, wide}, 8'h00);
        cmd(1'b0, 1'b0, 8'h83);
        chk(q, 8'h03);
        u_host.op(1'b0, 1'b0, 8'h3c, r);
        repeat (400) @(negedge mclk_i);
        u_host.narrow = 1'b0;
        chk({7'h00, wide}, 8'h01);
    endtask

    // Main sequence: reset, scenarios, verdict.
    initial begin
        repeat (20) @(negedge mclk_i);
        reset_n_i = 1'b1;
        t_setup();
        t_data();
        t_shift();
        t_busy();
        t_clear();
        t_nibble();
        conclude();
    end
endmodule
